// ---- rtl/ctm_regs.vh ----
// Summary of operation
// - Counter readable as low byte and two-bit high byte, upper bits zero.
// - Ten-bit compare-A value in low/high registers, cleared at reset.
// - Mode field: 00 compare output, 11 timer/counter, 10 PWM.
// - Clear-select low: clear on P match or overflow; both flags raised.
// - Clear-select high: clear on A match; only A flag raised.
// - Clear-select high, compare-A zero: overflow at 3FF, no A flag.
// - Compare mode: pin changes on A match or counter-on rising, never on P match.
// - A match drives high, low or toggles per action field; zero no change.
// - Counter-on rising loads pin with initial level bit.
// - Timer/counter mode clears and flags like compare mode, pin undriven.
// - PWM ignores clear-select; swap bit picks period and duty registers.
// - Swap zero: period is code times 128, code zero 1024; duty compare-A.
// - Duty at or above period holds output active whole period.
// - Swap one: period from compare-A; duty from code times 128.
// - PWM raises A flag on A match and P flag on P match.
// - PWM active level from initial bit; action enables; invert reverses.
// - PWM counter keeps running while output forced by action 00 or 01.
// - Counter-on rising resets counter; clearing keeps value.
// - Period field compared to counter bits 9 to 7.
// - Compare action decode: 00 none, 01 low, 10 high, 11 toggle.
// - PWM action decode: 00 inactive, 01 active, 10 waveform.
`ifndef CTM_REGS_VH
`define CTM_REGS_VH
`define CTM_ADDR_CTRL0 3'h0
`define CTM_ADDR_CTRL1 3'h1
`define CTM_ADDR_CNT_LO 3'h2
`define CTM_ADDR_CNT_HI 3'h3
`define CTM_ADDR_CMPA_LO 3'h4
`define CTM_ADDR_CMPA_HI 3'h5
`define CTM_ADDR_FLAGS 3'h6
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3
`define CTM_ACT_NONE 2'h0
`define CTM_ACT_LOW 2'h1
`define CTM_ACT_HIGH 2'h2
`define CTM_ACT_TOG 2'h3
`define CTM_CNT_MAX 10'h3FF
`define CTM_CNT_ZERO 10'h000
`define CTM_CNT_ONE 10'h001
`define CTM_BYTE_ZERO 8'h00
`define CTM_HI_PAD 6'h00
`define CTM_PER_ZERO 3'h0
`define CTM_PER_FULL 11'h400
`define CTM_LOW7_ZERO 7'h00
`define CTM_LOW7_MSB 6
`define CTM_P_MSB 9
`define CTM_P_LSB 7
`define CTM_HI_MSB 9
`define CTM_HI_LSB 8
`define CTM_LO_MSB 7
`define CTM_WD_HI_MSB 1
`define CTM_C0_PAUSE 7
`define CTM_C0_ON 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_ACT_HI 5
`define CTM_C1_ACT_LO 4
`define CTM_C1_INIT 3
`define CTM_C1_INV 2
`define CTM_C1_SWAP 1
`define CTM_C1_CLRSEL 0
`define CTM_FLAG_A 0
`define CTM_FLAG_P 1
`endif

// ---- rtl/ctm_timer.v ----
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_regs.vh"
module ctm_timer (
    input wire clk,
    input wire resetn,
    input wire tick,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata_ff,
    output reg out_ff,
    output reg out_en_ff,
    output reg match_a_ff,
    output reg match_p_ff
);
    reg rst_a_ff;
    reg rst_b_ff;
    wire rst_n;
    assign rst_n = rst_b_ff;

    // Reset enters asynchronously but is released on a clock edge
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_a_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_b_ff <= 1'b0;
        end else begin
            rst_b_ff <= rst_a_ff;
        end
    end

    reg [7:0] ctrl0_ff;
    reg [7:0] ctrl1_ff;
    // Compare-A is one ten-bit word; the bus writes it a byte at a time
    reg [9:0] cmpa_ff;
    reg [9:0] cnt_ff;
    reg on_d_ff;
    reg flag_a_ff;
    reg flag_p_ff;
    reg lvl_ff;

    wire pause;
    wire counter_on;
    wire [2:0] period_field;
    wire [1:0] mode;
    wire [1:0] action;
    wire init_lvl;
    wire invert;
    wire swap;
    wire clear_select;

    assign pause = ctrl0_ff[`CTM_C0_PAUSE];
    assign counter_on = ctrl0_ff[`CTM_C0_ON];
    assign period_field = ctrl0_ff[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
    assign mode = ctrl1_ff[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
    assign action = ctrl1_ff[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
    assign init_lvl = ctrl1_ff[`CTM_C1_INIT];
    assign invert = ctrl1_ff[`CTM_C1_INV];
    assign swap = ctrl1_ff[`CTM_C1_SWAP];
    assign clear_select = ctrl1_ff[`CTM_C1_CLRSEL];

    // Period code in counts, code zero means full range
    function [10:0] code_len;
        input [2:0] code;
        begin
            if (code == `CTM_PER_ZERO) begin
                code_len = `CTM_PER_FULL;
            end else begin
                code_len = {1'b0, code, `CTM_LOW7_ZERO};
            end
        end
    endfunction

    // Register select, shared by every write decode
    function wr_hit;
        input w;
        input [2:0] ad;
        input [2:0] a;
        begin
            wr_hit = w && (ad == a);
        end
    endfunction

    wire on_rise;
    wire step;
    wire [9:0] cnt_inc;
    wire hit_a;
    wire hit_p;
    wire ovf;
    wire is_pwm;

    assign on_rise = counter_on & ~on_d_ff;
    assign step = counter_on & ~pause & tick;
    assign cnt_inc = cnt_ff + `CTM_CNT_ONE;
    // Matches judged on the value being entered, so flags align with the count
    assign hit_a = step && (cnt_inc == cmpa_ff) && (cmpa_ff != `CTM_CNT_ZERO);
    assign hit_p = step
        && (cnt_inc[`CTM_P_MSB:`CTM_P_LSB] == period_field)
        && (cnt_inc[`CTM_LOW7_MSB:0] == `CTM_LOW7_ZERO)
        && (period_field != `CTM_PER_ZERO);
    assign ovf = step && (cnt_ff == `CTM_CNT_MAX);
    assign is_pwm = (mode == `CTM_MODE_PWM);

    // Clear and flag sources per mode
    reg clr;
    reg set_a;
    reg set_p;
    always @* begin
        clr = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        if (is_pwm) begin
            set_a = hit_a;
            set_p = hit_p;
            clr = swap ? hit_a : (hit_p | ovf);
        end else if (clear_select) begin
            clr = hit_a;
            set_a = hit_a;
        end else begin
            clr = hit_p | ovf;
            set_a = hit_a;
            set_p = hit_p;
        end
    end

    // Switching on restarts the count before any clear or step
    reg [9:0] nxt_cnt;
    always @* begin
        nxt_cnt = cnt_ff;
        if (on_rise) begin
            nxt_cnt = `CTM_CNT_ZERO;
        end else if (clr) begin
            nxt_cnt = `CTM_CNT_ZERO;
        end else if (step) begin
            nxt_cnt = cnt_inc;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= `CTM_CNT_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // PWM compare: duty and period lengths chosen by swap
    wire [10:0] per_len;
    wire [10:0] duty_len;
    wire duty_full;
    wire pwm_act;
    wire pwm_lvl;

    assign per_len = swap ? {1'b0, cmpa_ff} : code_len(period_field);
    assign duty_len = swap ? code_len(period_field) : {1'b0, cmpa_ff};
    assign duty_full = (duty_len >= per_len);
    assign pwm_act = duty_full | ({1'b0, cnt_ff} < duty_len);

    // Action 11 is undefined in PWM, so it parks at the inactive level
    reg pwm_raw;
    always @* begin
        case (action)
            `CTM_ACT_NONE: pwm_raw = 1'b0;
            `CTM_ACT_LOW: pwm_raw = 1'b1;
            `CTM_ACT_HIGH: pwm_raw = pwm_act;
            default: pwm_raw = 1'b0;
        endcase
    end
    assign pwm_lvl = (pwm_raw ? init_lvl : ~init_lvl) ^ invert;

    reg nxt_lvl;
    always @* begin
        nxt_lvl = lvl_ff;
        if (on_rise) begin
            nxt_lvl = init_lvl;
        end else if (mode == `CTM_MODE_CMP && set_a) begin
            case (action)
                `CTM_ACT_LOW: nxt_lvl = 1'b0;
                `CTM_ACT_HIGH: nxt_lvl = 1'b1;
                `CTM_ACT_TOG: nxt_lvl = ~lvl_ff;
                default: nxt_lvl = lvl_ff;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
        end
    end

    reg nxt_out;
    reg nxt_out_en;
    always @* begin
        nxt_out = 1'b0;
        nxt_out_en = 1'b0;
        case (mode)
            `CTM_MODE_CMP: begin
                nxt_out = lvl_ff ^ invert;
                nxt_out_en = 1'b1;
            end
            `CTM_MODE_PWM: begin
                nxt_out = pwm_lvl;
                nxt_out_en = 1'b1;
            end
            default: begin
                // Timer mode releases the pin to the load's pull-down
                nxt_out = 1'b0;
                nxt_out_en = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
            out_en_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            out_en_ff <= nxt_out_en;
        end
    end

    // Control fields take effect on the cycle after the write
    wire wr_ctrl0;
    wire wr_ctrl1;
    wire wr_cmpa_lo;
    wire wr_cmpa_hi;
    wire wr_flags;

    assign wr_ctrl0 = wr_hit(wr, addr, `CTM_ADDR_CTRL0);
    assign wr_ctrl1 = wr_hit(wr, addr, `CTM_ADDR_CTRL1);
    assign wr_cmpa_lo = wr_hit(wr, addr, `CTM_ADDR_CMPA_LO);
    assign wr_cmpa_hi = wr_hit(wr, addr, `CTM_ADDR_CMPA_HI);
    assign wr_flags = wr_hit(wr, addr, `CTM_ADDR_FLAGS);

    // Previous counter-on; resets to the off level, so no false edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_d_ff <= 1'b0;
        end else begin
            on_d_ff <= counter_on;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_ff <= `CTM_BYTE_ZERO;
        end else if (wr_ctrl0) begin
            ctrl0_ff <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= `CTM_BYTE_ZERO;
        end else if (wr_ctrl1) begin
            ctrl1_ff <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpa_ff <= `CTM_CNT_ZERO;
        end else begin
            if (wr_cmpa_lo) begin
                cmpa_ff[`CTM_LO_MSB:0] <= wdata;
            end
            if (wr_cmpa_hi) begin
                cmpa_ff[`CTM_HI_MSB:`CTM_HI_LSB] <= wdata[`CTM_WD_HI_MSB:0];
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_a_ff <= 1'b0;
        end else begin
            flag_a_ff <= set_a | (flag_a_ff & ~(wr_flags & wdata[`CTM_FLAG_A]));
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_p_ff <= 1'b0;
        end else begin
            flag_p_ff <= set_p | (flag_p_ff & ~(wr_flags & wdata[`CTM_FLAG_P]));
        end
    end

    // Match pulses mirror each flag set for one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_a_ff <= 1'b0;
        end else begin
            match_a_ff <= set_a;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_p_ff <= 1'b0;
        end else begin
            match_p_ff <= set_p;
        end
    end

    // Read data stands one cycle and is zero otherwise
    reg [7:0] nxt_rdata;
    always @* begin
        nxt_rdata = `CTM_BYTE_ZERO;
        if (rd) begin
            case (addr)
                `CTM_ADDR_CTRL0: nxt_rdata = ctrl0_ff;
                `CTM_ADDR_CTRL1: nxt_rdata = ctrl1_ff;
                `CTM_ADDR_CNT_LO: nxt_rdata = cnt_ff[`CTM_LO_MSB:0];
                `CTM_ADDR_CNT_HI: nxt_rdata = {`CTM_HI_PAD, cnt_ff[`CTM_HI_MSB:`CTM_HI_LSB]};
                `CTM_ADDR_CMPA_LO: nxt_rdata = cmpa_ff[`CTM_LO_MSB:0];
                `CTM_ADDR_CMPA_HI: nxt_rdata = {`CTM_HI_PAD, cmpa_ff[`CTM_HI_MSB:`CTM_HI_LSB]};
                `CTM_ADDR_FLAGS: nxt_rdata = {`CTM_HI_PAD, flag_p_ff, flag_a_ff};
                default: nxt_rdata = `CTM_BYTE_ZERO;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= `CTM_BYTE_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule
`default_nettype wire

// ---- sim/ctm_load.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctm_load (
    input wire logic clk,
    input wire logic pin,
    input wire logic en,
    input wire logic clr,
    output logic [10:0] high_cnt
);
    // Pull-down on the load, so an undriven pin reads low
    wire lvl = en & pin;
    always @(posedge clk) begin
        high_cnt <= clr ? 11'h000 : high_cnt + {10'h000, lvl};
    end
endmodule
`default_nettype wire

// ---- sim/ctm_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctm_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata_ff,
    input wire logic out_ff,
    input wire logic out_en_ff,
    input wire logic match_a_ff,
    input wire logic match_p_ff
);
    logic [7:0] c1_ff;
    logic [2:0] age_ff;
    // Control writes need a few cycles to reach the outputs
    wire quiet = age_ff == 3'h7;
    wire cmp = quiet && c1_ff[7:6] == 2'h0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c1_ff <= 8'h00;
            age_ff <= 3'h0;
        end else begin
            c1_ff <= (wr && addr == 3'h1) ? wdata : c1_ff;
            age_ff <= (wr && addr < 3'h2) ? 3'h0 : age_ff + {2'h0, !quiet};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    rd_idle_a: assert property (!$past(rd) |-> rdata_ff == 8'h00) else $error("stray data");
    cnt_hi_a: assert property (rd && addr == 3'h3 |=> rdata_ff[7:2] == 6'h00) else $error("hi");
    a_tick_a: assert property (match_a_ff |-> $past(tick)) else $error("a no tick");
    p_tick_a: assert property (match_p_ff |-> $past(tick)) else $error("p no tick");
    no_p_a: assert property (cmp && c1_ff[0] |-> !match_p_ff) else $error("p flag");
    tmr_idle_a: assert property (quiet && c1_ff[7:6] == 2'h3 |-> !out_en_ff && !out_ff)
        else $error("timer drives");
    drv_en_a: assert property (quiet && !c1_ff[6] |-> out_en_ff) else $error("no drive");
    pin_cause_a: assert property (cmp && $changed(out_ff) |-> $past(match_a_ff))
        else $error("pin moved");
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %0t bad %h", $time, a); end end
module tb;
    logic clk = 1'b0, resetn = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata_ff;
    logic out_ff, out_en_ff, match_a_ff, match_p_ff;
    logic [10:0] high_cnt;
    int err_count = 0, checked = 0, na = 0, np = 0;
    ctm_timer ctm_timer_inst (.clk, .resetn, .tick, .addr, .wdata, .wr, .rd, .rdata_ff,
        .out_ff, .out_en_ff, .match_a_ff, .match_p_ff);
    ctm_load ctm_load_inst (.clk, .pin(out_ff), .en(out_en_ff), .clr, .high_cnt);
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        na <= na + int'(match_a_ff);
        np <= np + int'(match_p_ff);
    end
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata_ff, e)
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic s_cmp;
        int a0, p0;
        w(3'h4, 8'h05);
        w(3'h5, 8'h00);
        for (int i = 0; i < 4; i++) begin
            w(3'h0, 8'h00);
            w(3'h1, {2'h0, i[1:0], i == 1, 3'h1});
            w(3'h0, 8'h08);
            tk(4);
            `CHK(out_ff, i == 1)
            r(3'h2, 8'h04);
            a0 = na;
            p0 = np;
            tk(1);
            `CHK(out_ff, i > 1)
            `CHK(na - a0, 1)
            `CHK(np - p0, 0)
            r(3'h2, 8'h00);
        end
    endtask
    task automatic s_per;
        int p0;
        w(3'h0, 8'h00);
        w(3'h1, 8'h00);
        w(3'h0, 8'h09);
        p0 = np;
        tk(127);
        r(3'h2, 8'h7F);
        tk(1);
        r(3'h2, 8'h00);
        `CHK(np - p0, 1)
    endtask
    // Counts over one whole period, so output latency cannot skew it
    task automatic pw(input logic [7:0] c1, input logic [9:0] a, input int per, input logic [10:0] hi);
        w(3'h0, 8'h01);
        w(3'h1, c1);
        w(3'h4, a[7:0]);
        w(3'h5, {6'h00, a[9:8]});
        w(3'h0, 8'h09);
        tick <= 1'b1;
        repeat (600) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (per) @(posedge clk);
        @(negedge clk);
        `CHK(high_cnt, hi)
        @(posedge clk);
        tick <= 1'b0;
    endtask
    task automatic conclude;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        r(3'h4, 8'h00);
        w(3'h1, 8'hC0);
        w(3'h4, 8'hA5);
        w(3'h5, 8'hFF);
        w(3'h2, 8'h55);
        r(3'h4, 8'hA5);
        r(3'h5, 8'h03);
        r(3'h2, 8'h00);
        r(3'h3, 8'h00);
        r(3'h7, 8'h00);
        s_cmp();
        s_per();
        pw(8'hA8, 10'h020, 128, 11'h020);
        pw(8'hA8, 10'h0C8, 128, 11'h080);
        pw(8'hAC, 10'h020, 128, 11'h060);
        pw(8'hAB, 10'h100, 256, 11'h080);
        pw(8'h98, 10'h020, 128, 11'h080);
        conclude();
    end
    initial begin
        // Sequence needs about a sixth of this span
        #200000;
        err_count++;
        conclude();
    end
endmodule
bind ctm_timer ctm_properties ctm_properties_inst (.clk, .resetn, .tick, .addr, .wdata, .wr,
    .rd, .rdata_ff, .out_ff, .out_en_ff, .match_a_ff, .match_p_ff);
`default_nettype wire
